// ### logic/zone_address_and_mac_verify.sv

`timescale 1ns/1ns
`default_nettype none
`include "zone_mac_regs.svh"

module zone_address_and_mac_verify (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,

  // Command from packet receiver
  input  wire logic         cmd_valid,
  output logic              cmd_ready,
  input  wire logic [7:0]   opcode,
  input  wire logic [7:0]   first_parameter,
  input  wire logic [15:0]  second_parameter,

  // Verify data field, held until verify_done
  input  wire logic [255:0] client_challenge,
  input  wire logic [255:0] client_response,
  input  wire logic [103:0] auxiliary_message_bytes,

  // Device state
  input  wire logic         config_lock_state,
  input  wire logic         value_lock_state,
  input  wire logic [1:0]   otp_policy,
  input  wire logic [15:0]  secret_slot_flag,
  input  wire logic [15:0]  encrypted_read_flag,
  input  wire logic [15:0]  slot_write_policy,
  input  wire logic [15:0]  read_key_zero,
  input  wire logic [15:0]  verify_source_bits,
  input  wire logic [255:0] scratch_digest,
  input  wire logic         scratch_digest_valid,
  input  wire logic         nonce_origin_flag,
  input  wire logic [63:0]  otp_bytes,
  input  wire logic [71:0]  serial_number_bytes,

  // Key slot fetch
  output logic [3:0]        key_slot,
  input  wire logic [255:0] key_bytes,

  // Memory access answer
  output logic              access_done,
  output logic              access_granted,
  output logic              access_error,
  output logic              access_write,
  output logic              access_block,
  output logic [1:0]        access_zone,
  output logic [6:0]        access_word,

  // Hash core
  output logic              sha_start,
  output logic [7:0]        sha_byte,
  output logic              sha_byte_valid,
  input  wire logic         sha_byte_ready,
  input  wire logic         sha_digest_valid,
  input  wire logic [255:0] sha_digest,

  // Verify answer
  output logic              verify_done,
  output logic              verify_error,
  output logic [7:0]        verify_result,
  output logic              copy_valid,
  output logic [3:0]        copy_slot
);

  // All registered state of the block
  typedef struct packed {
    // Sequencer position and latched verify command
    zone_mac_pkg::verify_state_t fsm;
    logic [6:0] idx;
    logic [7:0] mode;
    logic [3:0] slot;

    // Read and write answer
    logic       a_done;
    logic       a_grant;
    logic       a_err;
    logic       a_write;
    logic       a_block;
    logic [1:0] a_zone;
    logic [6:0] a_word;

    // Hash byte stream
    logic       s_start;
    logic [7:0] s_byte;
    logic       s_valid;

    // Verify answer and key copy
    logic       v_done;
    logic       v_err;
    logic [7:0] v_result;
    logic       c_valid;
    logic [3:0] c_slot;
  } state_t;

  // Registered state and its next value
  state_t     cur;
  state_t     next_cur;

  // Opcode decode
  logic       is_read;
  logic       is_write;
  logic       is_verify;

  // Checker and message builder results
  logic       chk_allowed;
  logic [6:0] chk_word;
  logic [7:0] msg_byte;

  // Verify mode decode and copy target
  logic [7:0] in_mode;
  logic       uses_scratch;
  logic       mode_bad;
  logic [3:0] target;

  // Policy and address checks for read and write
  // Combinational; its answer is registered in cur
  access_checker u_access_checker (
    .is_write            (is_write),
    .first_parameter     (first_parameter),
    .second_parameter    (second_parameter),
    .config_lock_state   (config_lock_state),
    .value_lock_state    (value_lock_state),
    .otp_policy          (otp_policy),
    .secret_slot_flag    (secret_slot_flag),
    .encrypted_read_flag (encrypted_read_flag),
    .slot_write_policy   (slot_write_policy),
    .allowed             (chk_allowed),
    .word_index          (chk_word)
  );

  // Hash message byte for the current stream position
  // Index and mode driven from registered state, so no loop through it
  mac_message_builder u_mac_message_builder (
    .byte_index              (cur.idx),
    .mode                    (cur.mode),
    .key_bytes               (key_bytes),
    .scratch_digest          (scratch_digest),
    .client_challenge        (client_challenge),
    .auxiliary_message_bytes (auxiliary_message_bytes),
    .otp_bytes               (otp_bytes),
    .serial_number_bytes     (serial_number_bytes),
    .msg_byte                (msg_byte)
  );

  // Command decode
  assign cmd_ready    = (cur.fsm == zone_mac_pkg::VFY_IDLE);
  assign is_read      = (opcode == `OPCODE_READ);
  assign is_write     = (opcode == `OPCODE_WRITE);
  assign is_verify    = (opcode == `OPCODE_MAC_VERIFY);

  // Verify mode: reserved bits, or scratch digest missing or of the wrong nonce origin
  assign in_mode      = first_parameter;
  assign uses_scratch = in_mode[`MODE_SECOND_SRC] | in_mode[`MODE_FIRST_SRC];
  assign mode_bad     = ((in_mode & `MODE_ZERO_MASK) != 8'h00) ||
                        (uses_scratch && (!scratch_digest_valid ||
                         in_mode[`MODE_NONCE_FIXED] != nonce_origin_flag));

  // Copy target from the latched slot selector
  assign target       = cur.slot[0] ? cur.slot : cur.slot + 4'h1;

  // Next state
  always_comb begin
    // Pulses fall back to low; everything else holds
    next_cur         = cur;
    next_cur.a_done  = 1'b0;
    next_cur.s_start = 1'b0;
    next_cur.v_done  = 1'b0;
    next_cur.c_valid = 1'b0;

    unique case (cur.fsm)
      zone_mac_pkg::VFY_IDLE: begin
        // Other opcodes are ignored and get no answer
        if (cmd_valid && (is_read || is_write)) begin
          // One-cycle answer; memory is only touched when granted
          // Word, zone and size are latched even when refused
          next_cur.a_done  = 1'b1;
          next_cur.a_grant = chk_allowed;
          next_cur.a_err   = !chk_allowed;
          next_cur.a_write = is_write;
          next_cur.a_block = first_parameter[`SIZE_BLOCK_BIT];
          next_cur.a_zone  = first_parameter[`ZONE_FIELD_MSB:0];
          next_cur.a_word  = chk_word;
        end else if (cmd_valid && is_verify) begin
          // Latch mode and slot, then refuse a bad mode at once
          next_cur.mode = in_mode;
          next_cur.slot = second_parameter[3:0];
          next_cur.idx  = 7'h00;
          if (mode_bad) begin
            next_cur.v_done   = 1'b1;
            next_cur.v_err    = 1'b1;
            next_cur.v_result = `RESULT_MISMATCH;
          end else begin
            next_cur.s_start = 1'b1;
            next_cur.fsm     = zone_mac_pkg::VFY_STREAM;
          end
        end
      end

      zone_mac_pkg::VFY_STREAM: begin
        // Feed message bytes with back-pressure from the hash core
        // A new byte loads only once the core has taken the last one
        if (!cur.s_valid || sha_byte_ready) begin
          if (cur.idx != `MSG_LEN) begin
            next_cur.s_byte  = msg_byte;
            next_cur.s_valid = 1'b1;
            next_cur.idx     = cur.idx + 7'h01;
          end else begin
            // Last byte taken: drop valid and wait for the digest
            next_cur.s_valid = 1'b0;
            next_cur.fsm     = zone_mac_pkg::VFY_WAIT;
          end
        end
      end

      zone_mac_pkg::VFY_WAIT: begin
        // Compare digest with the client response
        if (sha_digest_valid) begin
          next_cur.v_done = 1'b1;
          next_cur.v_err  = 1'b0;
          next_cur.fsm    = zone_mac_pkg::VFY_IDLE;
          if (sha_digest == client_response) begin
            next_cur.v_result = `RESULT_MATCH;
            // Copy needs the right mode, a zero read key and a matching source bit
            if ((cur.mode == `MODE_COPY_A || cur.mode == `MODE_COPY_B) && read_key_zero[target] &&
                verify_source_bits[target] == cur.mode[`MODE_NONCE_FIXED]) begin
              next_cur.c_valid = 1'b1;
              next_cur.c_slot  = target;
            end
          end else begin
            next_cur.v_result = `RESULT_MISMATCH;
          end
        end
      end

      // Illegal one-hot code returns to idle
      default: next_cur.fsm = zone_mac_pkg::VFY_IDLE;
    endcase
  end

  // State register
  // Asynchronous reset leaves the sequencer idle, every pulse low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur <= '{fsm: zone_mac_pkg::VFY_IDLE, default: '0};
    end else begin
      cur <= next_cur;
    end
  end

  // Key slot select
  assign key_slot       = cur.slot;

  // Read and write answer
  assign access_done    = cur.a_done;
  assign access_granted = cur.a_grant;
  assign access_error   = cur.a_err;
  assign access_write   = cur.a_write;
  assign access_block   = cur.a_block;
  assign access_zone    = cur.a_zone;
  assign access_word    = cur.a_word;

  // Hash byte stream
  assign sha_start      = cur.s_start;
  assign sha_byte       = cur.s_byte;
  assign sha_byte_valid = cur.s_valid;

  // Verify result and key copy
  assign verify_done    = cur.v_done;
  assign verify_error   = cur.v_err;
  assign verify_result  = cur.v_result;
  assign copy_valid     = cur.c_valid;
  assign copy_slot      = cur.c_slot;

endmodule
`default_nettype wire

// ### include/zone_mac_regs.svh
`ifndef ZONE_MAC_REGS_SVH
`define ZONE_MAC_REGS_SVH

// Command opcodes
`define OPCODE_READ        8'h02
`define OPCODE_WRITE       8'h12
`define OPCODE_MAC_VERIFY  8'h28

// Zone selector values in the first parameter
`define ZONE_CONFIG        2'h0
`define ZONE_OTP           2'h1
`define ZONE_DATA          2'h2
`define ZONE_FIELD_MSB     1
`define SIZE_BLOCK_BIT     7

// Address byte field positions
`define OFFSET_MSB         2
`define BLOCK_LSB          3
`define DATA_BLOCK_MSB     6
`define CONFIG_BLOCK_MSB   4
`define OTP_BLOCK_MSB      3

// Legal block limits
`define DATA_BLOCK_MAX     4'hf
`define CONFIG_BLOCK_MAX   2'h2
`define OTP_BLOCK_MAX      1'h1

// Configuration word limits
`define CONFIG_READ_MAX    5'h10
`define CONFIG_WORD_ONLY   5'h0a
`define CONFIG_WRITE_MIN   5'h04
`define CONFIG_WRITE_MAX   5'h0f

// Verify mode bits
`define MODE_SECOND_SRC    0
`define MODE_FIRST_SRC     1
`define MODE_NONCE_FIXED   2
`define MODE_OTP_BYTES     5
`define MODE_ZERO_MASK     8'hd8
`define MODE_COPY_A        8'h01
`define MODE_COPY_B        8'h05

// Hash message layout (byte positions)
`define MSG_LEN            7'h58
`define MSG_CHAL_BASE      7'h20
`define MSG_AUX0_BASE      7'h40
`define MSG_OTP_BASE       7'h44
`define MSG_AUX4_BASE      7'h4c
`define MSG_SN8_POS        7'h4f
`define MSG_AUX7_BASE      7'h50
`define MSG_SN0_BASE       7'h54
`define MSG_AUX11_BASE     7'h56

// Verify result bytes
`define RESULT_MATCH       8'h00
`define RESULT_MISMATCH    8'h01

`endif

// ### include/zone_mac_pkg.sv
package zone_mac_pkg;

  // One-time-programmable zone policy
  typedef enum logic [1:0] {
    OTP_READ_ONLY   = 2'h0,
    OTP_CONSUMPTION = 2'h1,
    OTP_LEGACY      = 2'h2
  } otp_policy_t;

  // Verify sequencer states
  typedef enum logic [2:0] {
    VFY_IDLE   = 3'b001,
    VFY_STREAM = 3'b010,
    VFY_WAIT   = 3'b100
  } verify_state_t;

endpackage

// ### logic/access_checker.sv
`timescale 1ns/1ns
`default_nettype none
`include "zone_mac_regs.svh"

module access_checker (
  // Request
  input  wire logic        is_write,
  input  wire logic [7:0]  first_parameter,
  input  wire logic [15:0] second_parameter,
  // Lock and policy state
  input  wire logic        config_lock_state,
  input  wire logic        value_lock_state,
  input  wire logic [1:0]  otp_policy,
  input  wire logic [15:0] secret_slot_flag,
  input  wire logic [15:0] encrypted_read_flag,
  input  wire logic [15:0] slot_write_policy,
  // Decoded result
  output logic             allowed,
  output logic [6:0]       word_index
);

  logic [1:0] zone;
  logic       blk_mode;
  logic [2:0] offset;
  logic [3:0] blk;
  logic [4:0] cfg_word;
  logic [7:0] addr;

  // Zone, address and policy checks
  always_comb begin
    addr       = second_parameter[7:0];
    zone       = first_parameter[`ZONE_FIELD_MSB:0];
    blk_mode   = first_parameter[`SIZE_BLOCK_BIT];
    offset     = addr[`OFFSET_MSB:0];
    blk        = addr[`DATA_BLOCK_MSB:`BLOCK_LSB];
    cfg_word   = {blk[1:0], offset};
    word_index = {blk, offset};
    allowed    = 1'b0;
    // Unused first-parameter bits, address high byte and bit 7 must be zero
    if (first_parameter[6:2] == 5'h00 && second_parameter[15:8] == 8'h00 && !addr[7]) begin
      unique case (zone)
        `ZONE_CONFIG: begin
          if (addr[6:5] == 2'h0 && blk[1:0] <= `CONFIG_BLOCK_MAX) begin
            if (!is_write) begin
              allowed = blk_mode ? (blk[1:0] != 2'h2)
                                 : (cfg_word <= `CONFIG_READ_MAX);
            end else if (!config_lock_state) begin
              allowed = blk_mode ? (blk[1:0] == 2'h1)
                                 : (cfg_word >= `CONFIG_WRITE_MIN && cfg_word <= `CONFIG_WRITE_MAX);
            end
          end
        end
        `ZONE_OTP: begin
          if (addr[6:4] == 3'h0) begin
            if (!is_write) begin
              allowed = value_lock_state && (otp_policy != 2'(zone_mac_pkg::OTP_LEGACY));
            end else if (config_lock_state) begin
              allowed = !value_lock_state || (otp_policy == 2'(zone_mac_pkg::OTP_CONSUMPTION));
            end
          end
        end
        `ZONE_DATA: begin
          // Every slot and offset reachable; secrecy limits word access
          if (!is_write) begin
            allowed = value_lock_state && !(secret_slot_flag[blk] && !encrypted_read_flag[blk])
                      && (blk_mode || !secret_slot_flag[blk]);
          end else if (config_lock_state) begin
            allowed = (!value_lock_state || slot_write_policy[blk])
                      && (blk_mode || !secret_slot_flag[blk]);
          end
        end
        default: allowed = 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### logic/mac_message_builder.sv
`timescale 1ns/1ns
`default_nettype none
`include "zone_mac_regs.svh"

module mac_message_builder (
  // Selection
  input  wire logic [6:0]   byte_index,
  input  wire logic [7:0]   mode,
  // Message sources
  input  wire logic [255:0] key_bytes,
  input  wire logic [255:0] scratch_digest,
  input  wire logic [255:0] client_challenge,
  input  wire logic [103:0] auxiliary_message_bytes,
  input  wire logic [63:0]  otp_bytes,
  input  wire logic [71:0]  serial_number_bytes,
  // Selected byte
  output logic [7:0]        msg_byte
);

  logic [4:0] rel;

  // Byte mux following the hash message layout
  always_comb begin
    rel      = byte_index[4:0];
    msg_byte = 8'h00;
    if (byte_index < `MSG_CHAL_BASE) begin
      msg_byte = mode[`MODE_FIRST_SRC] ? scratch_digest[8*rel +: 8] : key_bytes[8*rel +: 8];
    end else if (byte_index < `MSG_AUX0_BASE) begin
      msg_byte = mode[`MODE_SECOND_SRC] ? scratch_digest[8*rel +: 8] : client_challenge[8*rel +: 8];
    end else if (byte_index < `MSG_OTP_BASE) begin
      msg_byte = auxiliary_message_bytes[8*(byte_index - `MSG_AUX0_BASE) +: 8];
    end else if (byte_index < `MSG_AUX4_BASE) begin
      msg_byte = mode[`MODE_OTP_BYTES] ? otp_bytes[8*(byte_index - `MSG_OTP_BASE) +: 8] : 8'h00;
    end else if (byte_index < `MSG_SN8_POS) begin
      msg_byte = auxiliary_message_bytes[8*(byte_index - `MSG_AUX4_BASE + 7'h04) +: 8];
    end else if (byte_index == `MSG_SN8_POS) begin
      msg_byte = serial_number_bytes[71:64];
    end else if (byte_index < `MSG_SN0_BASE) begin
      msg_byte = auxiliary_message_bytes[8*(byte_index - `MSG_AUX7_BASE + 7'h07) +: 8];
    end else if (byte_index < `MSG_AUX11_BASE) begin
      msg_byte = serial_number_bytes[8*(byte_index - `MSG_SN0_BASE) +: 8];
    end else if (byte_index < `MSG_LEN) begin
      msg_byte = auxiliary_message_bytes[8*(byte_index - `MSG_AUX11_BASE + 7'h0b) +: 8];
    end
  end

endmodule
`default_nettype wire

// ### test/hash_core_model.sv
`timescale 1ns/1ns
`default_nettype none

module hash_core_model #(
  parameter logic [255:0] DIGEST = {8{32'h5a3c96e1}}
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Byte stream from the block
  input  wire logic         sha_start,
  input  wire logic [7:0]   sha_byte,
  input  wire logic         sha_byte_valid,
  output logic              sha_byte_ready,
  // Digest back to the block
  output logic              sha_digest_valid,
  output logic [255:0]      sha_digest,
  // Stall every other cycle when set
  input  wire logic         slow
);
  logic [7:0] msg [0:87];
  int         cnt;
  logic       tick;

  // Capture the message, pulse the digest after the last byte
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      tick <= 1'b0;
      sha_digest_valid <= 1'b0;
    end else begin
      tick <= ~tick;
      sha_digest_valid <= 1'b0;
      if (sha_start) begin
        cnt <= 0;
      end else if (sha_byte_valid && sha_byte_ready && cnt < 88) begin
        msg[cnt] <= sha_byte;
        cnt <= cnt + 1;
        if (cnt == 87) begin
          sha_digest_valid <= 1'b1;
        end
      end
    end
  end

  // Digest is only meaningful with its valid; otherwise show garbage
  assign sha_byte_ready = !slow || tick;
  assign sha_digest     = sha_digest_valid ? DIGEST : ~DIGEST;
endmodule

`default_nettype wire

// ### test/zone_mac_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module zone_mac_assertions (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Command
  input  wire logic        cmd_valid,
  input  wire logic        cmd_ready,
  input  wire logic [7:0]  opcode,
  input  wire logic [7:0]  first_parameter,
  input  wire logic [15:0] second_parameter,
  // Answers
  input  wire logic [3:0]  key_slot,
  input  wire logic        access_done,
  input  wire logic        access_granted,
  input  wire logic        access_error,
  input  wire logic [6:0]  access_word,
  input  wire logic        sha_start,
  input  wire logic        sha_byte_valid,
  input  wire logic        verify_done,
  input  wire logic        verify_error,
  input  wire logic [7:0]  verify_result,
  input  wire logic        copy_valid,
  input  wire logic [3:0]  copy_slot
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Command acceptance
  logic take;
  assign take = cmd_valid && cmd_ready;

  sequence rw_take;
    take && (opcode == 8'h02 || opcode == 8'h12);
  endsequence
  sequence vfy_take;
    take && opcode == 8'h28;
  endsequence

  chk_rw_answer: assert property (rw_take |=> access_done)
    else $error("read or write not answered");
  chk_done_cause: assert property (access_done |-> $past(take && (opcode == 8'h02 || opcode == 8'h12)))
    else $error("access answer without command");
  chk_reserved_zone: assert property (rw_take and first_parameter[1:0] == 2'h3 |=> access_error && !access_granted)
    else $error("reserved zone not refused");
  chk_grant_excl: assert property (access_done |-> access_granted ^ access_error)
    else $error("grant and error disagree");
  chk_word_index: assert property (rw_take and first_parameter[1:0] == 2'h2
    |=> access_word == $past(second_parameter[6:0]))
    else $error("word index wrong");
  chk_high_byte: assert property (rw_take and second_parameter[15:8] != 8'h00 |=> access_error)
    else $error("nonzero high address byte accepted");
  chk_cfg_low_write: assert property (rw_take and opcode == 8'h12 && first_parameter == 8'h00
    && second_parameter < 16'h0004 |=> access_error)
    else $error("low configuration word written");
  chk_cfg_read_top: assert property (rw_take and opcode == 8'h02 && first_parameter == 8'h00
    && second_parameter > 16'h0010 |=> access_error)
    else $error("configuration word above top read");
  chk_cfg_block_hi: assert property (rw_take and first_parameter == 8'h80 && second_parameter == 16'h0010
    |=> access_error)
    else $error("block access to upper configuration");
  chk_mode_zero: assert property (vfy_take and (first_parameter & 8'hd8) != 8'h00
    |=> verify_done && verify_error && verify_result == 8'h01)
    else $error("bad verify mode not refused");
  chk_key_slot: assert property (vfy_take and (first_parameter & 8'hdb) == 8'h00
    |=> sha_start && key_slot == $past(second_parameter[3:0]))
    else $error("key slot or hash start wrong");
  chk_busy: assert property (sha_byte_valid |-> !cmd_ready)
    else $error("command accepted while hashing");
  chk_copy_target: assert property (copy_valid |-> verify_done && verify_result == 8'h00
    && copy_slot == (key_slot | 4'h1))
    else $error("copy target wrong");
endmodule

bind zone_address_and_mac_verify zone_mac_assertions chk (.*);

`default_nettype wire

// ### test/zone_address_and_mac_verify_bench.sv
`timescale 1ns/1ns
`default_nettype none

module zone_address_and_mac_verify_bench;
  localparam logic [255:0] DIG = {8{32'h5a3c96e1}};
  logic ref_clk, rst, cmd_valid, cmd_ready, config_lock_state, value_lock_state, scratch_digest_valid;
  logic nonce_origin_flag, access_done, access_granted, access_error, access_write, access_block, slow;
  logic sha_start, sha_byte_valid, sha_byte_ready, sha_digest_valid, verify_done, verify_error, copy_valid;
  logic [7:0]   opcode, first_parameter, sha_byte, verify_result;
  logic [15:0]  second_parameter, secret_slot_flag, encrypted_read_flag, slot_write_policy;
  logic [15:0]  read_key_zero, verify_source_bits;
  logic [255:0] client_challenge, client_response, scratch_digest, key_bytes, sha_digest;
  logic [103:0] auxiliary_message_bytes;
  logic [63:0]  otp_bytes;
  logic [71:0]  serial_number_bytes;
  logic [1:0]   otp_policy, access_zone;
  logic [3:0]   key_slot, copy_slot;
  logic [6:0]   access_word;
  int           fails, n_tests, cyc;

  zone_address_and_mac_verify dut (.*);
  hash_core_model #(.DIGEST(DIG)) core (.*);

  // Clock, slot key fetch and hang guard
  always #10 ref_clk = ~ref_clk;
  function automatic logic [255:0] key_of(logic [3:0] s);
    return {32{4'ha, s}};
  endfunction
  assign key_bytes = key_of(key_slot);
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (fails == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected hash message byte
  function automatic logic [7:0] eb(int j, logic [7:0] m, logic [3:0] s);
    logic [255:0] k;
    k = key_of(s);
    if (j < 32) return m[1] ? scratch_digest[8*j+:8] : k[8*j+:8];
    if (j < 64) return m[0] ? scratch_digest[8*(j-32)+:8] : client_challenge[8*(j-32)+:8];
    if (j < 68) return auxiliary_message_bytes[8*(j-64)+:8];
    if (j < 76) return m[5] ? otp_bytes[8*(j-68)+:8] : 8'h00;
    if (j < 79) return auxiliary_message_bytes[8*(j-72)+:8];
    if (j == 79) return serial_number_bytes[71:64];
    if (j < 84) return auxiliary_message_bytes[8*(j-73)+:8];
    if (j < 86) return serial_number_bytes[8*(j-84)+:8];
    return auxiliary_message_bytes[8*(j-75)+:8];
  endfunction

  task automatic st(logic cl, logic vl, logic [1:0] pol, logic [15:0] sec);
    @(posedge ref_clk);
    config_lock_state <= cl;
    value_lock_state <= vl;
    otp_policy <= pol;
    secret_slot_flag <= sec;
  endtask

  // One read or write command
  task automatic rw(logic [7:0] op, logic [7:0] fp, logic [15:0] sp, logic err);
    @(posedge ref_clk);
    opcode <= op;
    first_parameter <= fp;
    second_parameter <= sp;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    chk("access_done", 1, access_done);
    chk("access_error", err, access_error);
    chk("access_granted", !err, access_granted);
    if (!err) chk("access_word", sp[6:0], access_word);
    chk("access_write", op == 8'h12, access_write);
    chk("access_block", fp[7], access_block);
    chk("access_zone", fp[1:0], access_zone);
  endtask

  // One verify command
  task automatic vfy(logic [7:0] m, logic [15:0] sl, logic good, logic err, logic cp);
    int i;
    @(posedge ref_clk);
    opcode <= 8'h28;
    first_parameter <= m;
    second_parameter <= sl;
    client_response <= good ? DIG : ~DIG;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    i = 0;
    while (verify_done !== 1'b1 && i < 400) begin
      @(posedge ref_clk);
      #1;
      i++;
    end
    chk("verify_done", 1, verify_done);
    chk("verify_error", err, verify_error);
    chk("verify_result", (err || !good) ? 1 : 0, verify_result);
    chk("copy_valid", cp, copy_valid);
    if (cp) chk("copy_slot", sl[3:0] | 4'h1, copy_slot);
    if (!err) chk("key_slot", sl[3:0], key_slot);
    for (i = 0; i < 88 && !err; i++) chk("message byte", eb(i, m, sl[3:0]), core.msg[i]);
  endtask

  initial begin
    ref_clk = 0; rst = 1; cmd_valid = 0; opcode = 0; first_parameter = 0; second_parameter = 0; slow = 0;
    config_lock_state = 0; value_lock_state = 0; otp_policy = 0; secret_slot_flag = 0;
    encrypted_read_flag = 0; slot_write_policy = 16'hffff; read_key_zero = 16'h0008; verify_source_bits = 0;
    scratch_digest = {8{32'hc001d00d}}; scratch_digest_valid = 1; nonce_origin_flag = 0;
    client_challenge = {32{8'h5e}}; client_response = DIG; otp_bytes = 64'h8f8e8d8c8b8a8988;
    auxiliary_message_bytes = 104'h9392979695940c0b0a00000008;
    serial_number_bytes = 72'h989796959493929190;
    fails = 0; n_tests = 0; cyc = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    // Locks open
    rw(8'h02, 8'h00, 16'h0000, 0);
    rw(8'h02, 8'h03, 16'h0000, 1);
    rw(8'h02, 8'h00, 16'h0100, 1);
    rw(8'h02, 8'h00, 16'h0018, 1);
    rw(8'h02, 8'h00, 16'h0010, 0);
    rw(8'h02, 8'h00, 16'h0011, 1);
    rw(8'h02, 8'h80, 16'h0010, 1);
    rw(8'h02, 8'h80, 16'h0008, 0);
    rw(8'h12, 8'h00, 16'h0003, 1);
    rw(8'h12, 8'h00, 16'h0004, 0);
    rw(8'h12, 8'h00, 16'h0010, 1);
    rw(8'h02, 8'h01, 16'h0000, 1);
    rw(8'h12, 8'h02, 16'h0000, 1);
    // Configuration locked, values open
    st(1, 0, zone_mac_pkg::OTP_READ_ONLY, 16'h0000);
    rw(8'h12, 8'h02, 16'h007f, 0);
    rw(8'h12, 8'h01, 16'h000f, 0);
    rw(8'h12, 8'h00, 16'h0004, 1);
    // Everything locked
    st(1, 1, zone_mac_pkg::OTP_READ_ONLY, 16'h0008);
    rw(8'h02, 8'h81, 16'h0008, 0);
    rw(8'h02, 8'h01, 16'h000f, 0);
    rw(8'h12, 8'h01, 16'h0000, 1);
    rw(8'h02, 8'h02, 16'h0010, 0);
    rw(8'h02, 8'h02, 16'h0018, 1);
    st(1, 1, zone_mac_pkg::OTP_CONSUMPTION, 16'h0000);
    rw(8'h12, 8'h01, 16'h0009, 0);
    st(1, 1, zone_mac_pkg::OTP_LEGACY, 16'h0000);
    rw(8'h02, 8'h01, 16'h0000, 1);
    // Verify commands
    vfy(8'h00, 16'h0013, 1, 0, 0);
    vfy(8'h01, 16'h0002, 1, 0, 1);
    vfy(8'h01, 16'h0004, 1, 0, 0);
    @(posedge ref_clk) slow <= 1'b1;
    vfy(8'h22, 16'h0007, 0, 0, 0);
    vfy(8'h08, 16'h0000, 1, 1, 0);
    vfy(8'h05, 16'h0003, 1, 1, 0);
    @(posedge ref_clk) nonce_origin_flag <= 1'b1;
    vfy(8'h05, 16'h0002, 1, 0, 0);
    end_sim();
  end
endmodule

`default_nettype wire
